//--- src/arc_pkg.sv
// Package for the converter reference and port split control block
package arc_pkg;

  // Register byte offsets on the AHB-Lite bus
  localparam logic [31:0] ARC_CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] ARC_MAP_OFFSET = 32'h0000_0004;
  localparam logic [31:0] ARC_INFO_OFFSET = 32'h0000_0008;
  localparam int ARC_ADDR_LSB = 2;
  localparam int ARC_ADDR_MSB = 7;

  // Control register layout
  localparam int ARC_CTRL_WIDTH = 8;
  localparam int ARC_REF_SEL_LSB = 4;
  localparam int ARC_REF_SEL_MSB = 5;
  localparam int ARC_SPLIT_LSB = 0;
  localparam int ARC_SPLIT_MSB = 3;
  localparam logic [7:0] ARC_CTRL_WRITE_MASK = 8'h3f;
  localparam logic [7:0] ARC_CTRL_RESET = 8'h00;

  // Reference source codes
  localparam logic [1:0] ARC_REF_RAILS = 2'h0;
  localparam logic [1:0] ARC_REF_EXT_POS = 2'h1;
  localparam logic [1:0] ARC_REF_EXT_NEG = 2'h2;
  localparam logic [1:0] ARC_REF_EXT_BOTH = 2'h3;

  // Channel count and the first channel missing on the small package
  localparam int ARC_NUM_CHANNELS = 16;
  localparam int ARC_SMALL_PKG_FIRST_ABSENT = 12;

  // Info register layout
  localparam int ARC_INFO_POS_EXT_BIT = 0;
  localparam int ARC_INFO_NEG_EXT_BIT = 1;
  localparam int ARC_INFO_SMALL_PKG_BIT = 2;
  localparam int ARC_INFO_COUNT_LSB = 8;
  localparam int ARC_INFO_COUNT_MSB = 12;

  // AHB-Lite transfer types
  localparam logic [1:0] ARC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] ARC_HTRANS_SEQ = 2'h3;
  localparam logic ARC_HRESP_OKAY = 1'b0;

  // Whole state of the top module
  typedef struct packed {
    logic [7:0] ctrl;
    logic wr_pend;
    logic [5:0] wr_index;
    logic [31:0] rdata;
  } arc_state_t;

  localparam arc_state_t ARC_STATE_RESET = '{
    ctrl: ARC_CTRL_RESET,
    wr_pend: 1'b0,
    wr_index: 6'h00,
    rdata: 32'h0000_0000
  };

endpackage : arc_pkg

//--- src/arc_split_decode.sv
// Decoder from the split code to per-channel analog enables
module arc_split_decode
  import arc_pkg::*;
#(
  parameter int NUM_CHANNELS = ARC_NUM_CHANNELS,
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Split code
  input wire logic [3:0] i_split_code,
  // Decoded channel map
  output logic [NUM_CHANNELS-1:0] o_analog_enable,
  output logic [4:0] o_digital_count
);

  // Elaboration check: the map function is built for the fixed channel count
  if (NUM_CHANNELS != ARC_NUM_CHANNELS) begin : g_bad_channels
    $error("arc_split_decode serves exactly sixteen channels");
  end

  // Code 0 keeps all analog; code n > 0 leaves channels below 15-n analog
  function automatic logic [15:0] split_map(input logic [3:0] code, input bit small_pkg);
    logic [15:0] map;
    map = 16'h0000;
    for (int ch = 0; ch < ARC_NUM_CHANNELS; ch++) begin
      if (code == 4'h0) begin
        map[ch] = 1'b1;
      end else begin
        map[ch] = (ch < (15 - int'(code)));
      end
      // Absent pins never get an analog enable
      if (small_pkg && ch >= ARC_SMALL_PKG_FIRST_ABSENT) begin
        map[ch] = 1'b0;
      end
    end
    return map;
  endfunction : split_map

  always_comb begin
    o_analog_enable = split_map(i_split_code, SMALL_PACKAGE);
    if (i_split_code == 4'h0) begin
      o_digital_count = 5'h00;
    end else begin
      o_digital_count = 5'({1'b0, i_split_code} + 5'h01);
    end
  end

endmodule : arc_split_decode

//--- src/arc_top.sv
// Converter reference select and analog/digital port split register with AHB-Lite slave
//
// Functional notes
// - Bits 7 and 6 of the control register are not implemented, read as zero and ignore writes.
// - Bits 5:4 pick the references: 00 rails, 01 external positive, 10 external negative, 11 both external.
// - Bits 3:0 split the sixteen channels, 0000 all analog up to 1111 all digital, digital from channel 15 down.
// - Power-on reset clears the six writable bits, giving rail references and all analog channels.
// - On the small package channels 12 to 15 are absent and their split setting has no effect.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
module arc_top
  import arc_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Converter reference steering
  output logic o_vref_pos_external,
  output logic o_vref_neg_external,
  output logic [1:0] o_reference_source_select,
  // Port split
  output logic [3:0] o_analog_digital_split_code,
  output logic [ARC_NUM_CHANNELS-1:0] o_analog_enable
);

  arc_state_t state_q;
  arc_state_t state_d;

  logic [ARC_NUM_CHANNELS-1:0] analog_map;
  logic [ARC_NUM_CHANNELS-1:0] next_map;
  logic [4:0] next_count;
  logic addr_phase;
  logic [5:0] addr_index;
  logic [1:0] ref_sel;
  logic [1:0] ref_pins;
  logic ctrl_write;
  logic [7:0] ctrl_next;

  // Word index of a byte address; the bus only makes whole-word accesses
  function automatic logic [5:0] word_index(input logic [31:0] addr);
    return addr[ARC_ADDR_MSB:ARC_ADDR_LSB];
  endfunction : word_index

  // Register offsets as word indices
  localparam logic [5:0] CTRL_INDEX = word_index(ARC_CTRL_OFFSET);
  localparam logic [5:0] MAP_INDEX = word_index(ARC_MAP_OFFSET);
  localparam logic [5:0] INFO_INDEX = word_index(ARC_INFO_OFFSET);

  // Field layout must agree with the fixed widths of the decode and the read mux
  if (ARC_CTRL_WIDTH != 8) begin : g_bad_ctrl_width
    $error("arc_top serves an eight bit control register only");
  end
  if (ARC_REF_SEL_MSB - ARC_REF_SEL_LSB != 1) begin : g_bad_ref_field
    $error("arc_top needs a two bit reference select field");
  end
  if (ARC_SPLIT_MSB - ARC_SPLIT_LSB != 3) begin : g_bad_split_field
    $error("arc_top needs a four bit split code field");
  end
  if (ARC_ADDR_MSB - ARC_ADDR_LSB != 5) begin : g_bad_addr_field
    $error("arc_top decodes a six bit word index");
  end
  if (ARC_INFO_COUNT_MSB - ARC_INFO_COUNT_LSB != 4) begin : g_bad_count_field
    $error("arc_top reports the digital count in five bits");
  end
  if (ARC_INFO_COUNT_MSB > 31) begin : g_bad_count_pos
    $error("arc_top info count field lies outside the data word");
  end
  if (ARC_NUM_CHANNELS > 16) begin : g_bad_channels
    $error("arc_top map register holds sixteen channels at most");
  end
  if (ARC_SMALL_PKG_FIRST_ABSENT > ARC_NUM_CHANNELS) begin : g_bad_small_pkg
    $error("arc_top first absent channel lies beyond the channel count");
  end
  if (CTRL_INDEX == MAP_INDEX || CTRL_INDEX == INFO_INDEX || MAP_INDEX == INFO_INDEX) begin : g_bad_offsets
    $error("arc_top register offsets overlap");
  end
  if (ARC_INFO_POS_EXT_BIT >= ARC_INFO_COUNT_LSB || ARC_INFO_NEG_EXT_BIT >= ARC_INFO_COUNT_LSB
      || ARC_INFO_SMALL_PKG_BIT >= ARC_INFO_COUNT_LSB) begin : g_bad_info_bits
    $error("arc_top info flags overlap the count field");
  end
  // Unimplemented bits must come out of reset as zero as well
  if ((ARC_CTRL_RESET & ~ARC_CTRL_WRITE_MASK) != 8'h00) begin : g_bad_reset
    $error("arc_top reset value sets unimplemented bits");
  end

  // Live map from the held control value drives the port logic
  arc_split_decode #(
    .NUM_CHANNELS(ARC_NUM_CHANNELS),
    .SMALL_PACKAGE(SMALL_PACKAGE)
  ) u_live_decode (
    .i_split_code(state_q.ctrl[ARC_SPLIT_MSB:ARC_SPLIT_LSB]),
    .o_analog_enable(analog_map),
    .o_digital_count()
  );

  // Second decode of the value about to be held, so a read right after a write sees it
  arc_split_decode #(
    .NUM_CHANNELS(ARC_NUM_CHANNELS),
    .SMALL_PACKAGE(SMALL_PACKAGE)
  ) u_next_decode (
    .i_split_code(ctrl_next[ARC_SPLIT_MSB:ARC_SPLIT_LSB]),
    .o_analog_enable(next_map),
    .o_digital_count(next_count)
  );

  // Only NONSEQ and SEQ start a transfer; IDLE and BUSY are ignored
  function automatic logic is_transfer(input logic [1:0] trans);
    return trans == ARC_HTRANS_NONSEQ || trans == ARC_HTRANS_SEQ;
  endfunction : is_transfer

  // Reference pins taken from outside for a select code, as {negative, positive}
  function automatic logic [1:0] ref_external(input logic [1:0] code);
    logic [1:0] pins;
    pins = 2'h0;
    case (code)
      ARC_REF_RAILS: begin
        pins = 2'h0;
      end
      ARC_REF_EXT_POS: begin
        pins = 2'h1;
      end
      ARC_REF_EXT_NEG: begin
        pins = 2'h2;
      end
      ARC_REF_EXT_BOTH: begin
        pins = 2'h3;
      end
      default: begin
        pins = 2'h0;
      end
    endcase
    return pins;
  endfunction : ref_external

  // Read value of one register from a given control byte and its decode
  function automatic logic [31:0] read_value(
    input logic [5:0] index,
    input logic [7:0] ctrl,
    input logic [15:0] map,
    input logic [4:0] count
  );
    logic [31:0] value;
    logic [1:0] pins;
    value = 32'h0000_0000;
    pins = ref_external(ctrl[ARC_REF_SEL_MSB:ARC_REF_SEL_LSB]);
    case (index)
      CTRL_INDEX: begin
        value[7:0] = ctrl & ARC_CTRL_WRITE_MASK;
      end
      MAP_INDEX: begin
        value[15:0] = map;
      end
      INFO_INDEX: begin
        value[ARC_INFO_POS_EXT_BIT] = pins[0];
        value[ARC_INFO_NEG_EXT_BIT] = pins[1];
        value[ARC_INFO_SMALL_PKG_BIT] = SMALL_PACKAGE;
        value[ARC_INFO_COUNT_MSB:ARC_INFO_COUNT_LSB] = count;
      end
      default: begin
        value = 32'h0000_0000;
      end
    endcase
    return value;
  endfunction : read_value

  // Size is not decoded: a narrow write still loads the whole control byte
  assign addr_phase = i_hsel && i_hready && is_transfer(i_htrans);
  assign addr_index = word_index(i_haddr);

  // Write data arrives one cycle after its address phase; the upper two bits are dropped and can never be set
  assign ctrl_write = state_q.wr_pend && state_q.wr_index == CTRL_INDEX;
  assign ctrl_next = ctrl_write ? (i_hwdata[7:0] & ARC_CTRL_WRITE_MASK) : state_q.ctrl;

  always_comb begin
    state_d = state_q;
    state_d.ctrl = ctrl_next;
    state_d.wr_pend = 1'b0;
    if (addr_phase) begin
      state_d.wr_pend = i_hwrite;
      state_d.wr_index = addr_index;
      if (!i_hwrite) begin
        // Forwarded value avoids a stale read after a back-to-back write
        state_d.rdata = read_value(addr_index, ctrl_next, next_map, next_count);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ARC_STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Zero wait states; unmapped offsets read zero and ignore writes
  assign o_hreadyout = 1'b1;
  assign o_hresp = ARC_HRESP_OKAY;
  assign o_hrdata = state_q.rdata;

  assign ref_sel = state_q.ctrl[ARC_REF_SEL_MSB:ARC_REF_SEL_LSB];
  assign o_reference_source_select = ref_sel;
  assign ref_pins = ref_external(ref_sel);
  assign o_vref_pos_external = ref_pins[0];
  assign o_vref_neg_external = ref_pins[1];

  assign o_analog_digital_split_code = state_q.ctrl[ARC_SPLIT_MSB:ARC_SPLIT_LSB];
  assign o_analog_enable = analog_map;

endmodule : arc_top

//--- tb/arc_top_props.sv
// Checker for the reference and port split register
module arc_top_props
  import arc_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Clock, reset and bus
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  // Block outputs
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic o_vref_pos_external,
  input wire logic o_vref_neg_external,
  input wire logic [1:0] o_reference_source_select,
  input wire logic [3:0] o_analog_digital_split_code,
  input wire logic [15:0] o_analog_enable
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic take;
  logic wr;
  logic [5:0] ctrl;
  logic [15:0] map;
  assign take = i_hsel && i_hready && i_htrans[1] && i_haddr[7:2] == 6'h00;
  assign wr = take && i_hwrite;
  assign ctrl = {o_reference_source_select, o_analog_digital_split_code};
  // Small package masks the absent top channels
  assign map = (ctrl[3:0] == 4'h0 ? 16'hffff : (16'h1 << (4'hf - ctrl[3:0])) - 16'h1)
    & (SMALL_PACKAGE ? 16'h0fff : 16'hffff);
  ctrl_write_a: assert property (wr ##1 1 |=> ctrl == $past(i_hwdata[5:0]))
    else $error("control write lost");
  ctrl_hold_a: assert property (!wr ##1 1 |=> $stable(ctrl))
    else $error("control changed without write");
  ctrl_read_a: assert property (take && !i_hwrite |=> o_hrdata == {26'h0, ctrl})
    else $error("control readback wrong");
  pos_ref_a: assert property (o_vref_pos_external == ctrl[4])
    else $error("positive reference wrong");
  neg_ref_a: assert property (o_vref_neg_external == ctrl[5])
    else $error("negative reference wrong");
  map_decode_a: assert property (o_analog_enable == map)
    else $error("analog map wrong");
  map_contig_a: assert property (((o_analog_enable + 16'h1) & o_analog_enable) == 16'h0)
    else $error("analog map not contiguous");
  bus_okay_a: assert property (o_hreadyout && o_hresp == ARC_HRESP_OKAY)
    else $error("bus not ready or not okay");
endmodule : arc_top_props

bind arc_top arc_top_props #(.SMALL_PACKAGE(SMALL_PACKAGE)) chk_u (.i_core_clk, .i_rst_n, .i_hsel,
  .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata,
  .o_vref_pos_external, .o_vref_neg_external, .o_reference_source_select, .o_analog_digital_split_code,
  .o_analog_enable);

//--- tb/arc_top_tb_top.sv
// Testbench for the reference and port split register
module arc_top_tb_top
  import arc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk, i_rst_n, i_hsel, i_hwrite, o_hreadyout, o_hresp;
  logic o_vref_pos_external, o_vref_neg_external;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
  logic [1:0] i_htrans, o_reference_source_select;
  logic [3:0] o_analog_digital_split_code;
  logic [15:0] o_analog_enable;
  logic s_hreadyout, s_hresp, s_vref_pos, s_vref_neg;
  logic [31:0] s_hrdata, rd_s;
  logic [1:0] s_ref_sel;
  logic [3:0] s_split;
  logic [15:0] s_analog_enable;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  arc_top dut_u (.i_core_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2),
    .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hresp, .o_hrdata, .o_vref_pos_external,
    .o_vref_neg_external, .o_reference_source_select, .o_analog_digital_split_code, .o_analog_enable);
  // Small package build on the same bus, so the absent channels are seen
  arc_top #(.SMALL_PACKAGE(1'b1)) dut_small_u (.i_core_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hsize(3'h2), .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout(s_hreadyout),
    .o_hresp(s_hresp), .o_hrdata(s_hrdata), .o_vref_pos_external(s_vref_pos), .o_vref_neg_external(s_vref_neg),
    .o_reference_source_select(s_ref_sel), .o_analog_digital_split_code(s_split),
    .o_analog_enable(s_analog_enable));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // Run needs about 150 cycles
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Called just after an edge; waits on hready, never on a fixed count
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    i_hsel <= 1'b1;
    i_haddr <= a;
    i_htrans <= ARC_HTRANS_NONSEQ;
    i_hwrite <= w;
    @(posedge i_core_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_core_clk);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    @(posedge i_core_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_core_clk);
    rd = o_hrdata;
    rd_s = s_hrdata;
  endtask : bus
  function automatic logic [15:0] amap(input int n);
    return (n == 0) ? 16'hffff : (16'h1 << (15 - n)) - 16'h1;
  endfunction : amap
  task automatic summarize();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    {i_rst_n, i_hsel, i_hwrite, i_haddr, i_hwdata, i_htrans} <= '0;
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    chk({o_vref_neg_external, o_vref_pos_external, o_reference_source_select, o_analog_enable}, 16'hffff);
    chk({s_vref_neg, s_vref_pos, s_ref_sel, s_split, o_analog_digital_split_code, s_analog_enable}, 16'h0fff);
    chk({o_hreadyout, o_hresp, s_hreadyout, s_hresp}, 4'ha);
    bus(ARC_CTRL_OFFSET, 1'b0, 32'h0);
    chk(rd, 32'h0);
    // Read after each write; the write's data phase has ended first, so forwarding is not exercised
    for (int i = 0; i < 16; i++) begin
      bus(ARC_CTRL_OFFSET, 1'b1, 32'hffff_ffc0 | ((i & 3) << 4) | i);
      bus(ARC_CTRL_OFFSET, 1'b0, 32'h0);
      chk(rd, ((i & 3) << 4) | i);
      chk(o_analog_enable, amap(i));
      chk({o_vref_neg_external, o_vref_pos_external}, i & 3);
      chk({s_vref_neg, s_vref_pos}, i & 3);
      chk({o_reference_source_select, o_analog_digital_split_code}, ((i & 3) << 4) | i);
      chk({s_ref_sel, s_split}, ((i & 3) << 4) | i);
      chk(s_analog_enable, amap(i) & 16'h0fff);
      bus(ARC_MAP_OFFSET, 1'b0, 32'h0);
      chk(rd, amap(i));
      chk(rd_s, amap(i) & 16'h0fff);
      bus(ARC_INFO_OFFSET, 1'b0, 32'h0);
      chk(rd, (((i == 0) ? 0 : i + 1) << 8) | (i & 3));
      chk(rd_s, (((i == 0) ? 0 : i + 1) << 8) | (i & 3) | 32'h4);
    end
    bus(ARC_MAP_OFFSET, 1'b1, 32'h0);
    bus(ARC_INFO_OFFSET, 1'b1, 32'hffff_ffff);
    bus(32'h0000_0040, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(ARC_CTRL_OFFSET, 1'b0, 32'h0);
    chk(rd, 32'h3f);
    i_rst_n <= 1'b0;
    @(posedge i_core_clk);
    chk({o_reference_source_select, o_analog_digital_split_code, o_analog_enable}, 16'hffff);
    chk({s_ref_sel, s_split, s_analog_enable}, 16'h0fff);
    i_rst_n <= 1'b1;
    bus(ARC_CTRL_OFFSET, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(ARC_INFO_OFFSET, 1'b0, 32'h0);
    chk(rd_s, 32'h4);
    summarize();
  end
endmodule : arc_top_tb_top
